// >>> dv/ssp_peer.sv
// Serial peer model that sends and takes asynchronous frames on the data lines.
`default_nettype none
module ssp_peer (
    input wire logic clk_i,
    input wire logic sck_i,
    input wire logic txd_i,
    output var logic rxd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // One bit lasts eight ticks of the clock divided by four.
    localparam int BIT_CLKS = 32;
    initial rxd_o = 1'b1;
    // Start low, data least significant first, chosen stop level, then idle high.
    task automatic send(input logic [8:0] d, input int nbits, input logic stop);
        @(posedge clk_i);
        rxd_o <= 1'b0;
        repeat (BIT_CLKS) @(posedge clk_i);
        for (int i = 0; i < nbits; i++) begin
            rxd_o <= d[i];
            repeat (BIT_CLKS) @(posedge clk_i);
        end
        rxd_o <= stop;
        repeat (BIT_CLKS) @(posedge clk_i);
        rxd_o <= 1'b1;
    endtask
    // Samples in mid-bit on the falling edge, where the line has settled.
    task automatic take(output logic [7:0] d, output logic stop);
        int n;
        n = 0;
        while (txd_i !== 1'b0 && n < 2000) begin
            @(negedge clk_i);
            n++;
        end
        repeat (BIT_CLKS / 2) @(negedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(negedge clk_i);
            d[i] = txd_i;
        end
        repeat (BIT_CLKS) @(negedge clk_i);
        stop = txd_i;
    endtask
    // Synchronous exchange: at each fall of the port's clock take its bit and set ours,
    // so our bit has half a clock period to settle before the port samples on the rise.
    task automatic swap(input logic [7:0] r, output logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            @(negedge sck_i);
            d[i] = txd_i;
            rxd_o <= r[i];
        end
    endtask
endmodule
`default_nettype wire

// >>> dv/ssp_top_tb.sv
// Self-checking bench for the serial port: registers, interrupt, transmit and receive.
`default_nettype none
module ssp_top_tb;
    import ssp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    ssp_wb_req_t req = '0;
    logic wb_ack_o, sck_o, sck_oe_n_o, txd_o, txd_oe_n_o, rxd, irq_o;
    logic [31:0] wb_dat_o;
    int n_errors = 0;
    int checked = 0;
    logic [7:0] q, d;
    logic stp;
    logic [1:0] ediv = 2'h0;
    // Clock at 40 MHz.
    always #12.5 clk_i = ~clk_i;
    // Free-running external baud clock at a quarter of the system clock.
    always @(posedge clk_i) ediv <= ediv + 2'h1;
    ssp_top ssp_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o), .sck_i(ediv[1]), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o),
        .txd_o(txd_o), .txd_oe_n_o(txd_oe_n_o), .rxd_i(rxd), .irq_o(irq_o));
    ssp_peer ssp_peer_inst (.clk_i(clk_i), .sck_i(sck_o), .txd_i(txd_o), .rxd_o(rxd));
    task automatic results();
        $display("counts: checked %0d, errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic cycle: raise after an edge, hold until ack is sampled high at a rising
    // edge, take the data at that same edge and release only then.
    task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                       output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h0, wd}};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) n_errors++;
        rd = wb_dat_o[7:0];
        req <= '0;
    endtask
    task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
        logic [7:0] x;
        bus(1'b1, adr, wd, x);
    endtask
    task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
        logic [7:0] x;
        bus(1'b0, adr, 8'h00, x);
        chk(x, exp);
    endtask
    // Reset values, the always-one clear bit and an unmapped place.
    task automatic t_reset();
        rd(8'h08, 8'h08);
        rd(8'h04, 8'h80);
        wr(8'h1c, 8'h55);
        rd(8'h1c, 8'h00);
        chk({7'h0, sck_oe_n_o}, 8'h01);
        $display("test reset done");
    endtask
    // Enabling the transmit request while the buffer is empty asks at once.
    task automatic t_irq_tx();
        wr(8'h04, 8'h81);
        @(negedge clk_i);
        chk({7'h0, irq_o}, 8'h01);
        wr(8'h04, 8'h80);
        @(negedge clk_i);
        chk({7'h0, irq_o}, 8'h00);
        $display("test tx request done");
    endtask
    // Two stop bits, eight data bits, clock divided by four, pins driven.
    task automatic t_tx();
        wr(8'h00, 8'h18);
        wr(8'h04, 8'hac);
        @(negedge clk_i);
        chk({6'h0, txd_oe_n_o, sck_oe_n_o}, 8'h00);
        fork
            wr(8'h10, 8'ha5);
            ssp_peer_inst.take(d, stp);
        join
        chk(d, 8'ha5);
        chk({7'h0, stp}, 8'h01);
        $display("test transmit done");
    endtask
    // A clean character on the external clock sets the full flag and raises the request.
    task automatic t_rx();
        wr(8'h00, 8'h0c);
        wr(8'h04, 8'hc2);
        ssp_peer_inst.send(9'h03c, 8, 1'b1);
        @(negedge clk_i);
        chk({7'h0, irq_o}, 8'h01);
        rd(8'h08, 8'h18);
        rd(8'h0c, 8'h3c);
        rd(8'h08, 8'h08);
        $display("test receive done");
    endtask
    // Wrong even parity: error flag only, no load; a zero in the clear bit wipes it.
    task automatic t_parity();
        wr(8'h00, 8'h48);
        ssp_peer_inst.send(9'h13c, 9, 1'b1);
        @(negedge clk_i);
        chk({7'h0, irq_o}, 8'h01);
        rd(8'h08, 8'h88);
        rd(8'h0c, 8'h3c);
        wr(8'h04, 8'h42);
        rd(8'h08, 8'h08);
        $display("test parity done");
    endtask
    // Synchronous exchange on the internal clock: the port clocks both lines itself.
    task automatic t_sync();
        wr(8'h00, 8'h88);
        wr(8'h04, 8'hec);
        fork
            wr(8'h10, 8'h5a);
            ssp_peer_inst.swap(8'hc3, q);
        join
        repeat (8) @(posedge clk_i);
        chk(q, 8'h5a);
        chk({7'h0, sck_o}, 8'h01);
        rd(8'h0c, 8'hc3);
        $display("test synchronous done");
    endtask
    // The tests together take a little over a thousand cycles; this limit leaves ample room.
    initial begin
        #(25 * 40000);
        n_errors++;
        results();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_irq_tx();
        t_tx();
        t_rx();
        t_parity();
        t_sync();
        results();
    end
endmodule
`default_nettype wire

// >>> logic/ssp_defs.svh
// Offsets, clock codes, divider counts and reset values of the serial port.
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

`define SSP_ADR_MODE1 8'h00
`define SSP_ADR_MODE2 8'h04
`define SSP_ADR_STATUS 8'h08
`define SSP_ADR_RXDATA 8'h0c
`define SSP_ADR_TXDATA 8'h10
`define SSP_ADR_RELOAD 8'h14

`define SSP_CLK_INT0 3'h0
`define SSP_CLK_INT1 3'h1
`define SSP_CLK_INT2 3'h2
`define SSP_CLK_BRG 3'h3
`define SSP_CLK_EXT 3'h4

`define SSP_PRE_MASK0 6'h03
`define SSP_PRE_MASK1 6'h0f
`define SSP_PRE_MASK2 6'h3f

`define SSP_ASYNC_LAST 3'h7
`define SSP_ASYNC_MID 3'h3
`define SSP_SYNC_BITS 4'h8

`define SSP_MODE1_RST 8'h00
`define SSP_MODE2_RST 7'h00
`define SSP_RELOAD_RST 8'h00
`define SSP_FLAGS_RST 5'h01

`endif

// >>> logic/ssp_pkg.sv
// Types shared by the serial port: bus request, control fields, flags and state.
`default_nettype none
package ssp_pkg;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } ssp_wb_req_t;

    typedef struct packed {
        logic sync_async_select;
        logic parity_present;
        logic parity_polarity;
        logic stop_length_select;
        logic character_length;
        logic [2:0] clock_source_select;
    } ssp_mode1_t;

    typedef struct packed {
        logic receive_enable;
        logic transmit_enable;
        logic baud_generator_run;
        logic data_output_enable;
        logic clock_output_enable;
        logic receive_irq_enable;
        logic transmit_irq_enable;
    } ssp_mode2_t;

    typedef struct packed {
        logic parity_error_flag;
        logic overrun_error_flag;
        logic framing_error_flag;
        logic receive_full_flag;
        logic transmit_empty_flag;
    } ssp_flags_t;

    typedef enum logic [1:0] {
        SSP_RX_IDLE = 2'b00,
        SSP_RX_RUN = 2'b01
    } ssp_rx_state_t;

    typedef enum logic {
        SSP_TX_IDLE = 1'b0,
        SSP_TX_RUN = 1'b1
    } ssp_tx_state_t;

    typedef struct packed {
        ssp_mode1_t mode1;
        ssp_mode2_t mode2;
        logic [7:0] reload;
        logic [7:0] tx_hold;
        logic [7:0] rx_data;
        ssp_flags_t flags;
        logic ack;
        logic [7:0] rdat;
        logic rxd_m;
        logic rxd_s;
        logic rxd_p;
        logic sck_m;
        logic sck_s;
        logic sck_p;
        logic [5:0] pre;
        logic [7:0] brg;
        logic phase;
        logic sck_out;
        logic txd;
        ssp_tx_state_t tx_st;
        logic [11:0] tx_sh;
        logic [3:0] tx_left;
        logic [2:0] tx_div;
        ssp_rx_state_t rx_st;
        logic [2:0] rx_div;
        logic [3:0] rx_idx;
        logic [8:0] rx_sh;
    } ssp_state_t;

endpackage
`default_nettype wire

// >>> logic/ssp_top.sv
// Serial port core: Wishbone registers, clock selection, transmitter and receiver.
//
// Overview of operation
// - Clock output enable makes the clock pin drive the serial clock out; the code holds it high except while a synchronous character goes out.
// - Three-bit clock select picks the source; code 100 is the external clock.
// - Data output enable makes the output pin drive transmit data.
// - Mode bit: asynchronous divides serial clock by eight, synchronous uses it directly; the code takes two ticks per bit from internal clocks.
// - In asynchronous mode the parity bit is present when enabled, both directions.
// - Parity polarity sets the parity sent and the parity checked.
// - Transmit one or two stop bits; receive checks a single stop bit.
// - Writing 0 to error clear clears error flags; 1 does nothing; reads 1.
// - Clearing receive enable mid-character finishes that character first.
// - Clearing transmit enable mid-character finishes that character first.
// - Baud generator start bit runs the dedicated baud generator.
// - Receive request while enabled and receive-full or any error flag set.
// - Transmit request while enabled and transmit-empty set.
// - Detected parity, overrun, framing errors set flags; data then invalid.
// - Receive-full sets on load and clears when the data register is read.
// - Transmit-empty clears on data write and sets when the shifter takes it.
// - Low three status bits read undefined and ignore writes.
// - Serial input shifts into a shift register, then the data register.
// - Frames: low start bit, data LSB first, high stop bits, idle high.
// - On error neither load nor set full; keep receiving later start bits.
// - Reception begins at the first falling edge of the input data.
`default_nettype none
`include "ssp_defs.svh"
module ssp_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire ssp_pkg::ssp_wb_req_t wb_req_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe_n_o,
    output logic txd_o,
    output logic txd_oe_n_o,
    input wire logic rxd_i,
    output logic irq_o
);
    import ssp_pkg::*;

    ssp_state_t st_r;
    ssp_state_t st_nxt;
    logic access;
    logic wr_en;
    logic rd_en;
    logic [7:0] wr_byte;
    logic ext_rise;
    logic ext_fall;
    logic brg_tick;
    logic sclk_tick;
    logic is_sync;
    logic use_ext;
    logic samp_evt;
    logic tx_bit_end;
    logic tx_start;
    logic rx_samp;
    logic rx_done;
    logic rx_fall;
    logic [15:0] fr;
    logic [3:0] k;
    logic [8:0] al;
    logic [7:0] rword;
    logic perr;
    logic ferr;
    logic oerr;

    // Address match; used by the register writes and by the receive-data read.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // Builds the frame bits (LSB goes out first) and the number of bit periods.
    function automatic logic [15:0] tx_frame(input logic [7:0] d, input ssp_mode1_t m);
        logic [11:0] f;
        logic [3:0] len;
        logic p;
        f = 12'hfff;
        len = m.character_length ? 4'h8 : 4'h7;
        p = ^(d & {m.character_length, 7'h7f}) ^ m.parity_polarity;
        if (m.sync_async_select) begin
            return {`SSP_SYNC_BITS, 4'hf, d};
        end
        f[0] = 1'b0;
        for (int i = 0; i < 7; i++) begin
            f[i + 1] = d[i];
        end
        if (m.character_length) begin
            f[8] = d[7];
        end
        if (m.parity_present) begin
            f[len + 4'h1] = p;
        end
        return {len + 4'(m.parity_present) + (m.stop_length_select ? 4'h3 : 4'h2), f};
    endfunction

    // Reset image of the whole state; the line and the clock pin rest high.
    function automatic ssp_state_t rst_state();
        ssp_state_t s;
        s = '0;
        s.mode1 = `SSP_MODE1_RST;
        s.mode2 = `SSP_MODE2_RST;
        s.reload = `SSP_RELOAD_RST;
        s.flags = `SSP_FLAGS_RST;
        s.rxd_m = 1'b1;
        s.rxd_s = 1'b1;
        s.rxd_p = 1'b1;
        s.sck_m = 1'b1;
        s.sck_s = 1'b1;
        s.sck_p = 1'b1;
        s.sck_out = 1'b1;
        s.txd = 1'b1;
        return s;
    endfunction

    // Bus decode: a request is taken once, and ack then blocks a second take.
    assign access = wb_req_i.cyc & wb_req_i.stb & ~st_r.ack;
    assign wr_en = access & wb_req_i.we & wb_req_i.sel[0];
    assign rd_en = access & ~wb_req_i.we;
    assign wr_byte = wb_req_i.dat[7:0];

    // Edges are taken from the second and third stages, never the first.
    assign ext_rise = st_r.sck_s & ~st_r.sck_p;
    assign ext_fall = ~st_r.sck_s & st_r.sck_p;
    assign rx_fall = st_r.rxd_p & ~st_r.rxd_s;
    assign brg_tick = st_r.mode2.baud_generator_run && st_r.brg == 8'h00;
    assign is_sync = st_r.mode1.sync_async_select;
    assign use_ext = st_r.mode1.clock_source_select == `SSP_CLK_EXT;

    // Serial clock source selection; unassigned codes give no clock at all.
    always_comb begin
        case (st_r.mode1.clock_source_select)
            `SSP_CLK_INT0: sclk_tick = (st_r.pre & `SSP_PRE_MASK0) == `SSP_PRE_MASK0;
            `SSP_CLK_INT1: sclk_tick = (st_r.pre & `SSP_PRE_MASK1) == `SSP_PRE_MASK1;
            `SSP_CLK_INT2: sclk_tick = (st_r.pre & `SSP_PRE_MASK2) == `SSP_PRE_MASK2;
            `SSP_CLK_BRG: sclk_tick = brg_tick;
            `SSP_CLK_EXT: sclk_tick = ext_rise;
            default: sclk_tick = 1'b0;
        endcase
    end

    // In synchronous mode data is sampled on the rising clock and moved after it.
    assign samp_evt = use_ext ? ext_rise : (sclk_tick & st_r.phase);
    assign tx_bit_end = is_sync ? samp_evt
                                : (sclk_tick && st_r.tx_div == `SSP_ASYNC_LAST);
    assign tx_start = st_r.tx_st == SSP_TX_IDLE && st_r.mode2.transmit_enable
                      && !st_r.flags.transmit_empty_flag
                      && !(wr_en && hit(wb_req_i.adr, `SSP_ADR_TXDATA));
    assign rx_samp = sclk_tick && st_r.rx_div == `SSP_ASYNC_MID;
    assign fr = tx_frame(st_r.tx_hold, st_r.mode1);

    // Receive completion: bits after start, alignment of the shift register, errors.
    always_comb begin
        k = (st_r.mode1.character_length ? 4'h8 : 4'h7) + 4'(st_r.mode1.parity_present);
        al = st_r.rx_sh >> (4'h9 - k);
        rx_done = 1'b0;
        rword = al[7:0] & {st_r.mode1.character_length, 7'h7f};
        perr = 1'b0;
        ferr = 1'b0;
        oerr = st_r.flags.receive_full_flag;
        if (is_sync) begin
            rword = {st_r.rxd_s, st_r.rx_sh[8:2]};
            rx_done = samp_evt && st_r.rx_idx == `SSP_SYNC_BITS - 4'h1
                      && (st_r.mode2.receive_enable || st_r.rx_idx != 4'h0);
        end else if (st_r.rx_st == SSP_RX_RUN && rx_samp && st_r.rx_idx == k + 4'h1) begin
            rx_done = 1'b1;
            ferr = ~st_r.rxd_s;
            perr = st_r.mode1.parity_present
                   && ((^rword ^ al[k - 4'h1]) != st_r.mode1.parity_polarity);
        end
    end

    // Next-state logic; software clears are applied first so hardware sets win.
    always_comb begin
        st_nxt = st_r;
        st_nxt.rxd_m = rxd_i;
        st_nxt.rxd_s = st_r.rxd_m;
        st_nxt.rxd_p = st_r.rxd_s;
        st_nxt.sck_m = sck_i;
        st_nxt.sck_s = st_r.sck_m;
        st_nxt.sck_p = st_r.sck_s;
        st_nxt.pre = st_r.pre + 6'h01;
        st_nxt.ack = access;
        // The generator reloads while stopped so it starts a full period.
        if (!st_r.mode2.baud_generator_run || brg_tick) begin
            st_nxt.brg = st_r.reload;
        end else begin
            st_nxt.brg = st_r.brg - 8'h01;
        end
        // Register writes; only the low byte lane carries data.
        if (wr_en) begin
            if (hit(wb_req_i.adr, `SSP_ADR_MODE1)) begin
                st_nxt.mode1 = wr_byte;
            end
            if (hit(wb_req_i.adr, `SSP_ADR_MODE2)) begin
                st_nxt.mode2 = wr_byte[6:0];
                if (!wr_byte[7]) begin
                    st_nxt.flags.parity_error_flag = 1'b0;
                    st_nxt.flags.overrun_error_flag = 1'b0;
                    st_nxt.flags.framing_error_flag = 1'b0;
                end
            end
            if (hit(wb_req_i.adr, `SSP_ADR_TXDATA)) begin
                st_nxt.tx_hold = wr_byte;
                st_nxt.flags.transmit_empty_flag = 1'b0;
            end
            if (hit(wb_req_i.adr, `SSP_ADR_RELOAD)) begin
                st_nxt.reload = wr_byte;
            end
        end
        // Register reads; the data byte is captured with the ack.
        if (rd_en) begin
            case (wb_req_i.adr)
                `SSP_ADR_MODE1: st_nxt.rdat = st_r.mode1;
                `SSP_ADR_MODE2: st_nxt.rdat = {1'b1, st_r.mode2};
                `SSP_ADR_STATUS: st_nxt.rdat = {st_r.flags, 3'h0};
                `SSP_ADR_RXDATA: st_nxt.rdat = st_r.rx_data;
                `SSP_ADR_TXDATA: st_nxt.rdat = st_r.tx_hold;
                `SSP_ADR_RELOAD: st_nxt.rdat = st_r.reload;
                default: st_nxt.rdat = 8'h00;
            endcase
            if (hit(wb_req_i.adr, `SSP_ADR_RXDATA)) begin
                st_nxt.flags.receive_full_flag = 1'b0;
            end
        end
        // Transmitter: enable is sampled only between characters.
        case (st_r.tx_st)
            SSP_TX_IDLE: begin
                st_nxt.phase = 1'b0;
                if (tx_start) begin
                    st_nxt.tx_sh = fr[11:0];
                    st_nxt.tx_left = fr[15:12];
                    st_nxt.tx_div = 3'h0;
                    st_nxt.tx_st = SSP_TX_RUN;
                    st_nxt.flags.transmit_empty_flag = 1'b1;
                end
            end
            SSP_TX_RUN: begin
                if (sclk_tick) begin
                    st_nxt.tx_div = st_r.tx_div + 3'h1;
                    st_nxt.phase = ~st_r.phase;
                end
                if (tx_bit_end) begin
                    st_nxt.tx_sh = {1'b1, st_r.tx_sh[11:1]};
                    st_nxt.tx_left = st_r.tx_left - 4'h1;
                    if (st_r.tx_left == 4'h1) begin
                        st_nxt.tx_st = SSP_TX_IDLE;
                    end
                end
            end
            default: st_nxt.tx_st = SSP_TX_IDLE;
        endcase
        st_nxt.txd = (st_nxt.tx_st == SSP_TX_RUN) ? st_nxt.tx_sh[0] : 1'b1;
        // The clock pin idles high and pulses low while a synchronous character goes out.
        st_nxt.sck_out = !(is_sync && st_nxt.tx_st == SSP_TX_RUN) || !st_nxt.phase;
        // Receiver.
        if (is_sync) begin
            st_nxt.rx_st = SSP_RX_IDLE;
            if (samp_evt && (st_r.mode2.receive_enable || st_r.rx_idx != 4'h0)) begin
                st_nxt.rx_sh = {st_r.rxd_s, st_r.rx_sh[8:1]};
                st_nxt.rx_idx = rx_done ? 4'h0 : st_r.rx_idx + 4'h1;
            end
        end else begin
            case (st_r.rx_st)
                SSP_RX_IDLE: begin
                    if (st_r.mode2.receive_enable && rx_fall) begin
                        st_nxt.rx_st = SSP_RX_RUN;
                        st_nxt.rx_div = 3'h0;
                        st_nxt.rx_idx = 4'h0;
                    end
                end
                SSP_RX_RUN: begin
                    if (sclk_tick) begin
                        st_nxt.rx_div = st_r.rx_div + 3'h1;
                    end
                    if (rx_samp) begin
                        st_nxt.rx_idx = st_r.rx_idx + 4'h1;
                        if (st_r.rx_idx == 4'h0 && st_r.rxd_s) begin
                            st_nxt.rx_st = SSP_RX_IDLE;
                        end else if (st_r.rx_idx != 4'h0 && !rx_done) begin
                            st_nxt.rx_sh = {st_r.rxd_s, st_r.rx_sh[8:1]};
                        end
                        if (rx_done) begin
                            st_nxt.rx_st = SSP_RX_IDLE;
                        end
                    end
                end
                default: st_nxt.rx_st = SSP_RX_IDLE;
            endcase
            // An idle receiver keeps no bit count, so a later mode change starts clean.
            if (st_nxt.rx_st == SSP_RX_IDLE) begin
                st_nxt.rx_idx = 4'h0;
            end
        end
        // Completion: errors block the load and leave the old data in place.
        if (rx_done) begin
            if (perr || ferr || oerr) begin
                // Built on the next value, so a clear in this cycle still wipes the others.
                st_nxt.flags.parity_error_flag |= perr;
                st_nxt.flags.overrun_error_flag |= oerr;
                st_nxt.flags.framing_error_flag |= ferr;
            end else begin
                st_nxt.rx_data = rword;
                st_nxt.flags.receive_full_flag = 1'b1;
            end
        end
    end

    // The single state register; reset is synchronous.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= rst_state();
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs; pin directions follow the enables and ignore the port direction.
    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = {24'h000000, st_r.rdat};
    assign sck_o = st_r.sck_out;
    assign sck_oe_n_o = ~st_r.mode2.clock_output_enable;
    assign txd_o = st_r.txd;
    assign txd_oe_n_o = ~st_r.mode2.data_output_enable;
    assign irq_o = (st_r.mode2.receive_irq_enable && (st_r.flags.receive_full_flag
                   || st_r.flags.parity_error_flag || st_r.flags.overrun_error_flag
                   || st_r.flags.framing_error_flag))
                   || (st_r.mode2.transmit_irq_enable && st_r.flags.transmit_empty_flag);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_mode2_wr;
        wr_en && hit(wb_req_i.adr, `SSP_ADR_MODE2);
    endsequence
    sequence s_tx_wr;
        wr_en && hit(wb_req_i.adr, `SSP_ADR_TXDATA);
    endsequence
    sequence s_rx_rd;
        rd_en && hit(wb_req_i.adr, `SSP_ADR_RXDATA) && !rx_done;
    endsequence

    a_clk_pin_drive: assert property (s_mode2_wr ##0 wr_byte[2] |=> !sck_oe_n_o)
        else $error("clock pin not driven after clock output enable");
    a_ext_clk_edge: assert property (use_ext && sclk_tick |-> $past(st_r.sck_m))
        else $error("external clock tick without a pin edge");
    a_data_pin_drive: assert property (s_mode2_wr ##0 !wr_byte[3] |=> txd_oe_n_o)
        else $error("data pin still driven after output disable");
    a_async_div_eight: assert property (
        !is_sync && st_r.tx_st == SSP_TX_RUN && $past(st_r.tx_st) == SSP_TX_RUN
        && $changed(st_r.tx_left) |-> $past(st_r.tx_div) == 3'h7)
        else $error("asynchronous bit ended off the eighth tick");
    a_err_clear_wr: assert property (
        s_mode2_wr ##0 !wr_byte[7] && !rx_done
        |=> !st_r.flags.parity_error_flag && !st_r.flags.framing_error_flag
        && !st_r.flags.overrun_error_flag)
        else $error("error flags survived a clear");
    a_rx_full_clear: assert property (
        s_rx_rd |=> !st_r.flags.receive_full_flag ##1 wb_ack_o == 1'b0)
        else $error("receive full not cleared by data read");
    a_tx_empty_clear: assert property (
        s_tx_wr |=> !st_r.flags.transmit_empty_flag && wb_ack_o)
        else $error("transmit empty not cleared by data write");
    a_tx_start_low: assert property (
        tx_start && !is_sync |=> st_r.flags.transmit_empty_flag ##0 !txd_o)
        else $error("start bit not low when transmission begins");
    a_rx_start_edge: assert property (
        !is_sync && st_r.rx_st == SSP_RX_IDLE
        && st_r.mode2.receive_enable && rx_fall |=> st_r.rx_st == SSP_RX_RUN)
        else $error("falling edge did not start reception");
    a_irq_rx_full: assert property (
        st_r.mode2.receive_irq_enable && $rose(st_r.flags.receive_full_flag) |-> irq_o)
        else $error("receive request missing");

endmodule
`default_nettype wire
